// ==== hdl/kip_port.sv ====
// Eight-pin key input port with two interrupt groups
`timescale 1ns/1ps
`default_nettype none

module kip_port
	import kip_pkg::*;
#(
	parameter int ADDR_W = KIP_ADDR_W,
	parameter int DATA_W = KIP_DATA_W
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [KIP_PINS-1:0] key_pins_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic irq_out
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	generate
		if (ADDR_W != 16 || DATA_W != 4) begin : g_bad_width
			$error("kip_port: only a 16-bit address and 4-bit data are served");
		end
		if (KIP_GROUPS * KIP_GRP_W != KIP_PINS) begin : g_bad_split
			$error("kip_port: the groups must cover every pin");
		end
	endgenerate

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] pins;
		logic [7:0] sel;
		logic [7:0] cmp;
		logic [1:0] mask;
		logic [1:0] flag;
		logic [1:0] match;
		logic [3:0] rdata;
		logic irq;
	} kip_state_s;

	kip_state_s st_r;
	kip_state_s st_nxt;

	// ----------------------------------------
	// Per-group match detection
	// ----------------------------------------
	logic [1:0] match_now;
	logic [1:0] grp_event;

	genvar g;
	generate
		for (g = 0; g < KIP_GROUPS; g++) begin : g_grp
			logic [3:0] diff;
			logic [3:0] lvl_g;
			logic [3:0] sel_g;
			logic [3:0] cmp_g;
			assign lvl_g = st_r.pins[g*4 +: 4];
			assign sel_g = st_r.sel[g*4 +: 4];
			assign cmp_g = st_r.cmp[g*4 +: 4];
			// R04: compare against stored level
			// R03: unselected pins masked out
			assign diff = (lvl_g ^ cmp_g) & sel_g;
			assign match_now[g] = (diff == 4'h0);
			// R05: match to mismatch edge
			// R06: mismatch to mismatch ignored
			assign grp_event[g] = st_r.match[g] & ~match_now[g];
		end
	endgenerate

	// ----------------------------------------
	// Pin acceptance
	// ----------------------------------------
	logic [KIP_PINS-1:0] pin_agree;
	logic [KIP_PINS-1:0] pin_next;

	genvar p;
	generate
		for (p = 0; p < KIP_PINS; p++) begin : g_pin
			// R13: second and third stage agree
			assign pin_agree[p] = (st_r.sync2[p] == st_r.sync3[p]);
			// A pin caught mid-change keeps its last accepted level
			assign pin_next[p] = pin_agree[p] ? st_r.sync3[p] : st_r.pins[p];
		end
	endgenerate

	// ----------------------------------------
	// Write data slices
	// ----------------------------------------
	logic [3:0] wdata;
	logic wbit;
	logic [1:0] wpair;

	assign wdata = reg_wdata_in[3:0];
	assign wbit = reg_wdata_in[0];
	assign wpair = reg_wdata_in[1:0];

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [15:0] a;
	logic hit_sel0;
	logic hit_lvl0;
	logic hit_cmp0;
	logic hit_sel1;
	logic hit_lvl1;
	logic hit_cmp1;
	logic hit_stat;
	logic hit_clr;
	logic hit_en;
	logic hit_mask0;
	logic hit_mask1;
	logic hit_flag0;
	logic hit_flag1;

	assign a = reg_addr_in[15:0];

	// Hits are one-hot, so no two registers answer one address
	always_comb begin
		hit_sel0 = 1'b0;
		hit_lvl0 = 1'b0;
		hit_cmp0 = 1'b0;
		hit_sel1 = 1'b0;
		hit_lvl1 = 1'b0;
		hit_cmp1 = 1'b0;
		hit_stat = 1'b0;
		hit_clr = 1'b0;
		hit_en = 1'b0;
		hit_mask0 = 1'b0;
		hit_mask1 = 1'b0;
		hit_flag0 = 1'b0;
		hit_flag1 = 1'b0;
		if (a == KIP_SEL0_OFS) begin
			hit_sel0 = 1'b1;
		end else if (a == KIP_LVL0_OFS) begin
			hit_lvl0 = 1'b1;
		end else if (a == KIP_CMP0_OFS) begin
			hit_cmp0 = 1'b1;
		end else if (a == KIP_SEL1_OFS) begin
			hit_sel1 = 1'b1;
		end else if (a == KIP_LVL1_OFS) begin
			hit_lvl1 = 1'b1;
		end else if (a == KIP_CMP1_OFS) begin
			hit_cmp1 = 1'b1;
		end else if (a == KIP_IRQ_STAT_OFS) begin
			hit_stat = 1'b1;
		end else if (a == KIP_IRQ_CLR_OFS) begin
			hit_clr = 1'b1;
		end else if (a == KIP_IRQ_EN_OFS) begin
			hit_en = 1'b1;
		end else if (a == KIP_MASK0_OFS) begin
			hit_mask0 = 1'b1;
		end else if (a == KIP_MASK1_OFS) begin
			hit_mask1 = 1'b1;
		end else if (a == KIP_FLAG0_OFS) begin
			hit_flag0 = 1'b1;
		end else if (a == KIP_FLAG1_OFS) begin
			hit_flag1 = 1'b1;
		end
	end

	// ----------------------------------------
	// One- and two-bit register views
	// ----------------------------------------
	logic [3:0] view_mask0;
	logic [3:0] view_mask1;
	logic [3:0] view_flag0;
	logic [3:0] view_flag1;
	logic [3:0] view_stat;
	logic [3:0] view_en;

	// Unused upper bits read as zero
	assign view_mask0 = {3'h0, st_r.mask[0]};
	assign view_mask1 = {3'h0, st_r.mask[1]};
	assign view_flag0 = {3'h0, st_r.flag[0]};
	assign view_flag1 = {3'h0, st_r.flag[1]};
	assign view_stat = {2'h0, st_r.flag};
	assign view_en = {2'h0, st_r.mask};

	// ----------------------------------------
	// Write strobes per register
	// ----------------------------------------
	logic wr_sel0;
	logic wr_cmp0;
	logic wr_sel1;
	logic wr_cmp1;
	logic wr_mask0;
	logic wr_mask1;
	logic wr_en;
	logic wr_flag0;
	logic wr_flag1;
	logic wr_clr;

	// R02: level and status addresses take no write
	assign wr_sel0 = reg_wr_in & hit_sel0;
	assign wr_cmp0 = reg_wr_in & hit_cmp0;
	assign wr_sel1 = reg_wr_in & hit_sel1;
	assign wr_cmp1 = reg_wr_in & hit_cmp1;
	assign wr_mask0 = reg_wr_in & hit_mask0;
	assign wr_mask1 = reg_wr_in & hit_mask1;
	assign wr_en = reg_wr_in & hit_en;
	assign wr_flag0 = reg_wr_in & hit_flag0;
	assign wr_flag1 = reg_wr_in & hit_flag1;
	assign wr_clr = reg_wr_in & hit_clr;

	logic [1:0] clr;

	// R10: write one clears, zero leaves alone
	always_comb begin
		clr = 2'h0;
		if (wr_flag0) begin
			clr[0] = wbit;
		end
		if (wr_flag1) begin
			clr[1] = wbit;
		end
		if (wr_clr) begin
			clr = wpair;
		end
	end

	// ----------------------------------------
	// Factor flags
	// ----------------------------------------
	logic [KIP_GROUPS-1:0] flag_next;

	genvar f;
	generate
		for (f = 0; f < KIP_GROUPS; f++) begin : g_flag
			// R07: one flag per group
			// R08: set regardless of mask, set beats clear
			assign flag_next[f] = (st_r.flag[f] & ~clr[f]) | grp_event[f];
		end
	endgenerate

	// ----------------------------------------
	// Read data select
	// ----------------------------------------
	logic [3:0] rd_word;

	// Unmapped addresses read as zero
	always_comb begin
		rd_word = KIP_RD_RST;
		if (hit_sel0) begin
			rd_word = st_r.sel[3:0];
		end else if (hit_lvl0) begin
			// R01: synchronised pin levels
			rd_word = st_r.pins[3:0];
		end else if (hit_cmp0) begin
			rd_word = st_r.cmp[3:0];
		end else if (hit_sel1) begin
			rd_word = st_r.sel[7:4];
		end else if (hit_lvl1) begin
			rd_word = st_r.pins[7:4];
		end else if (hit_cmp1) begin
			rd_word = st_r.cmp[7:4];
		end else if (hit_mask0) begin
			rd_word = view_mask0;
		end else if (hit_mask1) begin
			rd_word = view_mask1;
		end else if (hit_flag0) begin
			rd_word = view_flag0;
		end else if (hit_flag1) begin
			rd_word = view_flag1;
		end else if (hit_stat) begin
			rd_word = view_stat;
		end else if (hit_en) begin
			rd_word = view_en;
		end
	end

	// ----------------------------------------
	// Reset image
	// ----------------------------------------
	kip_state_s rst_state;

	// Match history starts as all-match so release raises nothing
	always_comb begin
		rst_state.sync1 = KIP_PIN_RST;
		rst_state.sync2 = KIP_PIN_RST;
		rst_state.sync3 = KIP_PIN_RST;
		rst_state.pins = KIP_PIN_RST;
		rst_state.sel = KIP_SEL_RST;
		rst_state.cmp = KIP_CMP_RST;
		rst_state.mask = KIP_MASK_RST;
		rst_state.flag = KIP_FLAG_RST;
		rst_state.match = KIP_MATCH_RST;
		rst_state.rdata = KIP_RD_RST;
		rst_state.irq = 1'h0;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// R13: three-stage pin synchroniser
		st_nxt.sync1 = key_pins_in;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync3 = st_r.sync2;
		st_nxt.pins = pin_next;
		// R13: previous cycle match state
		st_nxt.match = match_now;

		// Configuration registers
		if (wr_sel0) begin
			st_nxt.sel[3:0] = wdata;
		end
		if (wr_cmp0) begin
			st_nxt.cmp[3:0] = wdata;
		end
		if (wr_sel1) begin
			st_nxt.sel[7:4] = wdata;
		end
		if (wr_cmp1) begin
			st_nxt.cmp[7:4] = wdata;
		end
		if (wr_mask0) begin
			st_nxt.mask[0] = wbit;
		end
		if (wr_mask1) begin
			st_nxt.mask[1] = wbit;
		end
		if (wr_en) begin
			st_nxt.mask = wpair;
		end

		st_nxt.flag = flag_next;

		// R09: masked request to CPU
		st_nxt.irq = |(st_nxt.flag & st_nxt.mask);

		// Read data stand in the cycle after the strobe only
		st_nxt.rdata = KIP_RD_RST;
		if (reg_rd_in) begin
			st_nxt.rdata = rd_word;
		end

		// R12: reset values
		if (sys_rst_in) begin
			st_nxt = rst_state;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out = st_r.rdata;
	assign irq_out = st_r.irq;

endmodule : kip_port

`default_nettype wire

// ==== inc/kip_pkg.sv ====
// Constants and register map of the key input port with group interrupts
// What this block does
// R01: Data registers read live pin levels
// R02: Writes to pin level registers ignored
// R03: Only selected pins join group condition
// R04: Compare bit one falling, zero rising
// R05: Event when selected pins leave full match
// R06: Mismatch to other mismatch raises nothing
// R07: Two groups, pins 0-3 and 4-7
// R08: Event sets factor flag regardless of mask
// R09: Mask bit gates request to CPU
// R10: Writing one clears factor flag
// R11: Handler clears flag before re-enabling interrupts
// R12: Reset clears select, compare, mask, flags
// R13: Synchronise pins, compare match each cycle
package kip_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int KIP_ADDR_W = 16;
	localparam int KIP_DATA_W = 4;
	localparam int KIP_GROUPS = 2;
	localparam int KIP_GRP_W = 4;
	localparam int KIP_PINS = 8;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [15:0] KIP_SEL0_OFS = 16'hff20;
	localparam logic [15:0] KIP_LVL0_OFS = 16'hff21;
	localparam logic [15:0] KIP_CMP0_OFS = 16'hff22;
	localparam logic [15:0] KIP_SEL1_OFS = 16'hff24;
	localparam logic [15:0] KIP_LVL1_OFS = 16'hff25;
	localparam logic [15:0] KIP_CMP1_OFS = 16'hff26;
	localparam logic [15:0] KIP_IRQ_STAT_OFS = 16'hff28;
	localparam logic [15:0] KIP_IRQ_CLR_OFS = 16'hff29;
	localparam logic [15:0] KIP_IRQ_EN_OFS = 16'hff2a;
	localparam logic [15:0] KIP_MASK0_OFS = 16'hffe4;
	localparam logic [15:0] KIP_MASK1_OFS = 16'hffe5;
	localparam logic [15:0] KIP_FLAG0_OFS = 16'hfff4;
	localparam logic [15:0] KIP_FLAG1_OFS = 16'hfff5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] KIP_SEL_RST = 8'h00;
	localparam logic [7:0] KIP_CMP_RST = 8'h00;
	localparam logic [1:0] KIP_MASK_RST = 2'h0;
	localparam logic [1:0] KIP_FLAG_RST = 2'h0;
	localparam logic [1:0] KIP_MATCH_RST = 2'h3;
	localparam logic [7:0] KIP_PIN_RST = 8'h00;
	localparam logic [3:0] KIP_RD_RST = 4'h0;

endpackage : kip_pkg

// ==== tb/kip_checker.sv ====
// Port-level assertions for the key input port
`timescale 1ns/1ps
`default_nettype none
module kip_checker (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] key_pins_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [3:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [3:0] reg_rdata_out,
	input wire logic irq_out
);
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	AST_RST: assert property (disable iff (1'b0) sys_rst_in |=> !irq_out)
		else $error("irq in reset");
	AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 4'h0)
		else $error("stray data");
	AST_PINS: assert property (
		$stable(key_pins_in)[*5] ##0 reg_rd_in && reg_addr_in == 16'hff21
		|=> $stable(key_pins_in) -> reg_rdata_out == key_pins_in[3:0]) else $error("pin level");
	AST_BIT0: assert property (
		reg_rd_in && reg_addr_in[15:4] == 12'hfff |=> reg_rdata_out[3:1] == 3'h0)
		else $error("flag width");
	AST_QUIET: assert property (
		($stable(key_pins_in) && !reg_wr_in)[*8] |=> !$rose(irq_out)) else $error("no cause");
	AST_HOLD: assert property (irq_out && !reg_wr_in |=> irq_out)
		else $error("irq dropped");
	AST_W1C0: assert property (
		irq_out && reg_wr_in && reg_addr_in[15:4] == 12'hfff && reg_wdata_in == 4'h0
		|=> irq_out) else $error("zero cleared");
	AST_MASK: assert property (
		reg_wr_in && reg_addr_in == 16'hff2a && reg_wdata_in == 4'h0 ##1 !reg_wr_in
		|=> !irq_out) else $error("masked irq");
endmodule : kip_checker
bind kip_port kip_checker chk (.*);
`default_nettype wire

// ==== tb/kip_keys.sv ====
// Switches driving the key pins
`timescale 1ns/1ps
`default_nettype none
module kip_keys (
	input wire logic clk_in,
	input wire logic [7:0] level_in,
	output logic [7:0] key_pins_out
);
	initial key_pins_out = 8'h00;
	always @(posedge clk_in) begin
		key_pins_out <= level_in;
	end
endmodule : kip_keys
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the key input port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic irq;
	logic [15:0] ad = 16'h0;
	logic [3:0] wd = 4'h0;
	logic [3:0] rdat;
	logic [7:0] lvl = 8'h00;
	logic [7:0] pins;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	initial forever #2.5 clk = ~clk;
	kip_keys keys (.clk_in(clk), .level_in(lvl), .key_pins_out(pins));
	kip_port dut (.core_clk_in(clk), .sys_rst_in(rst), .key_pins_in(pins), .reg_addr_in(ad),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .irq_out(irq));
	task automatic finish_test;
		if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [3:0] g, input logic [3:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : cmp
	task automatic wrr(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wrr
	task automatic rdc(input logic [15:0] a, input logic [3:0] e);
		@(posedge clk);
		rd <= 1'b1;
		ad <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdat, e);
	endtask : rdc
	task automatic pin(input logic [7:0] v);
		lvl <= v;
		repeat (8) @(posedge clk);
	endtask : pin
	task automatic t_regs;
		logic [15:0] a[8] = '{16'hff20, 16'hff22, 16'hff24, 16'hff26, 16'hffe4, 16'hffe5,
			16'hfff4, 16'hfff5};
		foreach (a[i]) rdc(a[i], 4'h0);
		pin(8'ha5);
		rdc(16'hff21, 4'h5);
		rdc(16'hff25, 4'ha);
		wrr(16'hff21, 4'hf);
		rdc(16'hff21, 4'h5);
		rdc(16'hff23, 4'h0);
	endtask : t_regs
	task automatic t_grp0;
		pin(8'h0a);
		wrr(16'hff22, 4'ha);
		wrr(16'hff20, 4'he);
		wrr(16'hffe4, 4'h1);
		pin(8'h0b);
		rdc(16'hfff4, 4'h0);
		pin(8'h03);
		rdc(16'hfff4, 4'h1);
		cmp({3'h0, irq}, 4'h1);
		wrr(16'hfff4, 4'h0);
		rdc(16'hfff4, 4'h1);
		wrr(16'hfff4, 4'h1);
		rdc(16'hfff4, 4'h0);
		pin(8'h07);
		rdc(16'hfff4, 4'h0);
	endtask : t_grp0
	task automatic t_grp1;
		wrr(16'hff24, 4'h1);
		pin(8'h17);
		rdc(16'hfff5, 4'h1);
		rdc(16'hfff4, 4'h0);
		cmp({3'h0, irq}, 4'h0);
		rdc(16'hff28, 4'h2);
		wrr(16'hff2a, 4'h3);
		cmp({3'h0, irq}, 4'h1);
		wrr(16'hff29, 4'h2);
		cmp({3'h0, irq}, 4'h0);
		pin(8'h07);
		pin(8'h17);
		cmp({3'h0, irq}, 4'h1);
		wrr(16'hff2a, 4'h0);
		cmp({3'h0, irq}, 4'h0);
		rdc(16'hfff5, 4'h1);
	endtask : t_grp1
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			$display("wrong value at %0t: timeout", $time);
			finish_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_grp0();
		t_grp1();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
